//--- logic/od_defines.svh
// Register offsets, field positions, reset values and deadzone constants for the orientation detector
`ifndef OD_DEFINES_SVH
`define OD_DEFINES_SVH

// Register offsets
`define OD_RATE_CONFIG_OFS    8'h3A
`define OD_ORIENTATION_RESULT_CONFIG_OFS  8'h3B
`define OD_ORIENTATION_RESULT_RESULT_OFS  8'h3C

// Reset values
`define OD_RATE_CONFIG_RST    8'h00
`define OD_ORIENTATION_RESULT_CONFIG_RST  8'h00
`define OD_ORIENTATION_RESULT_RESULT_RST  8'h00

// Config fields
`define OD_DEADZONE_MSB       6
`define OD_DEADZONE_LSB       4
`define OD_DIVISOR_MSB        2
`define OD_DIVISOR_LSB        0

// Result fields
`define OD_PLANAR_VALID_BIT   6
`define OD_PLANAR_CODE_MSB    5
`define OD_PLANAR_CODE_LSB    4
`define OD_SPATIAL_VALID_BIT  3
`define OD_SPATIAL_CODE_MSB   2
`define OD_SPATIAL_CODE_LSB   0

// Planar codes
`define OD_P2_POS_X           2'h0
`define OD_P2_NEG_X           2'h1
`define OD_P2_POS_Y           2'h2
`define OD_P2_NEG_Y           2'h3

// Spatial codes
`define OD_S3_POS_Z           3'h1
`define OD_S3_POS_Y           3'h2
`define OD_S3_POS_X           3'h3
`define OD_S3_NEG_X           3'h4
`define OD_S3_NEG_Y           3'h5
`define OD_S3_NEG_Z           3'h6

// tan(45 deg - n*1.8 deg) in Q0.8, edge of the valid region per deadzone code
`define OD_TAN_Q8_0           8'hFF
`define OD_TAN_Q8_1           8'hF0
`define OD_TAN_Q8_2           8'hE1
`define OD_TAN_Q8_3           8'hD3
`define OD_TAN_Q8_4           8'hC6
`define OD_TAN_Q8_5           8'hB9
`define OD_TAN_Q8_6           8'hAD
`define OD_TAN_Q8_7           8'hA2

`endif

//--- logic/od_pkg.sv
// Types shared by the orientation detector modules
package od_pkg;

  // One acceleration sample, two's complement
  typedef logic signed [15:0] od_sample_t;

  // Axis chosen as closest to gravity
  typedef enum logic [1:0] {
    OD_AXIS_X,
    OD_AXIS_Y,
    OD_AXIS_Z
  } od_axis_t;

endpackage

//--- logic/od_mavg.sv
// Moving-average filter for one acceleration axis
`timescale 1ns/1ps

module od_mavg #(
  parameter int W       = 16,
  parameter int MAX_LOG = 8
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                clear,
  input  wire logic [2:0]          depth_code,
  input  wire logic                in_valid,
  input  wire logic signed [W-1:0] in_data,
  output logic                     out_valid,
  output logic signed [W-1:0]      out_data
);

  localparam int DEPTH = 1 << MAX_LOG;

  logic signed [W-1:0]         hist_reg [DEPTH];  // Sample history ring
  logic [MAX_LOG-1:0]          wr_ptr_reg;        // Next slot to write
  logic signed [W+MAX_LOG-1:0] sum_reg;           // Running window sum
  logic signed [W+MAX_LOG-1:0] sum_next;          // Sum including new sample
  logic [MAX_LOG:0]            depth_w;           // Window length in samples
  logic [MAX_LOG-1:0]          old_idx;           // Sample leaving the window
  logic                        out_valid_reg;     // Filtered sample strobe
  logic signed [W-1:0]         out_data_reg;      // Filtered sample

  // Window length and the slot that drops out of it
  always_comb begin
    depth_w  = (MAX_LOG+1)'(1) << (4'(depth_code) + 4'h1);
    old_idx  = wr_ptr_reg - depth_w[MAX_LOG-1:0];
    sum_next = sum_reg + (W+MAX_LOG)'(in_data) - (W+MAX_LOG)'(hist_reg[old_idx]);
  end

  // History and running sum; cleared slots count as zero while filling
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      for (int i = 0; i < DEPTH; i++) begin
        hist_reg[i] <= '0;
      end
      wr_ptr_reg <= '0;
      sum_reg    <= '0;
    end else if (in_valid) begin
      hist_reg[wr_ptr_reg] <= in_data;
      wr_ptr_reg           <= wr_ptr_reg + 1'b1;
      sum_reg              <= sum_next;
    end
  end

  // Divide by window length; averaging sets the bandwidth at sensor rate over depth
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end else begin
      out_valid_reg <= in_valid;
      if (in_valid) begin
        out_data_reg <= W'(sum_next >>> (4'(depth_code) + 4'h1));
      end
    end
  end

  assign out_valid = out_valid_reg;
  assign out_data  = out_data_reg;

endmodule

//--- logic/od_detector.sv
// Orientation detector: filters three axes and reports planar and spatial orientation
`timescale 1ns/1ps
`include "od_defines.svh"

// Three axes are averaged apart, then the filtered vector is classified twice:
// in the x-y plane and in space. Both answers land together in the result
// register one cycle after the filters publish, so a host never sees one new
// and one stale.
// A configuration write that would change the data rate or the averaging depth
// empties the filters and the result; the next answers ramp up from zero, so
// the host should let one full window pass before trusting them.
// Area was traded for an exact window: each axis keeps its whole history in flops.

module od_detector (
  // Clock and synchronous reset
  input  wire logic               clk,
  input  wire logic               rst,
  // One sample per output data period, all axes together
  input  wire od_pkg::od_sample_t accel_x,
  input  wire od_pkg::od_sample_t accel_y,
  input  wire od_pkg::od_sample_t accel_z,
  input  wire logic               sample_valid,
  // Register port; read data follows the address by one cycle
  input  wire logic [7:0]         reg_addr,
  input  wire logic               reg_wr,
  input  wire logic [7:0]         reg_wdata,
  output      logic [7:0]         reg_rdata
);

  // Configuration and result storage
  logic [7:0]         rate_config_reg;    // Output data rate setting
  logic [7:0]         orientation_result_config_reg;  // Deadzone and divisor codes
  logic [7:0]         orientation_result_result_reg;  // Published orientation
  logic [7:0]         reg_rdata_reg;      // Registered read data
  logic               restart;            // Clears filters and result
  // Configuration fields split out for the datapath
  logic [2:0]         dz_code;            // Deadzone code
  logic [2:0]         div_code;           // Divisor code
  // Filter outputs and their magnitudes
  logic [2:0]         fv;                 // Filter outputs valid
  od_pkg::od_sample_t fx;                 // Filtered x
  od_pkg::od_sample_t fy;                 // Filtered y
  od_pkg::od_sample_t fz;                 // Filtered z
  logic [16:0]        ax;                 // |x|
  logic [16:0]        ay;                 // |y|
  logic [16:0]        az;                 // |z|
  // Classifier outputs, settled a cycle before the result register takes them
  logic [1:0]         planar_code;        // Planar orientation code
  logic [2:0]         spatial_code;       // Spatial orientation code
  logic               planar_valid;       // Outside planar deadzone
  logic               spatial_valid;      // Outside spatial deadzone

  // Magnitude of a sample, one bit wider so -32768 fits
  function automatic logic [16:0] od_abs(input od_pkg::od_sample_t v);
    logic [16:0] r;
    // Negate in 17 bits so the most negative sample does not wrap
    r = v[15] ? 17'(-17'(signed'(v))) : 17'(v);
    return r;
  endfunction

  // Valid-region edge, tan(45 - half deadzone), in Q0.8
  function automatic logic [7:0] od_tan_q8(input logic [2:0] code);
    logic [7:0] t;
    // One entry per 3.6 degree step of total deadzone, half on each side
    unique case (code)
      3'h0: t = `OD_TAN_Q8_0;
      3'h1: t = `OD_TAN_Q8_1;
      3'h2: t = `OD_TAN_Q8_2;
      3'h3: t = `OD_TAN_Q8_3;
      3'h4: t = `OD_TAN_Q8_4;
      3'h5: t = `OD_TAN_Q8_5;
      3'h6: t = `OD_TAN_Q8_6;
      3'h7: t = `OD_TAN_Q8_7;
    endcase
    return t;
  endfunction

  // Minor axis stays inside the region: minor < tan(edge) * major
  function automatic logic od_in_region(input logic [16:0] minor, input logic [16:0] major,
                                        input logic [2:0] code);
    logic [24:0] lhs;
    logic [24:0] rhs;
    // Strict less-than: a vector exactly on the edge counts as deadzone
    // Both sides fit in 25 bits, so no bit of the major axis is lost
    lhs = {minor, 8'h00};
    rhs = 25'(major) * 25'(od_tan_q8(code));
    return lhs < rhs;
  endfunction

  assign dz_code  = orientation_result_config_reg[`OD_DEADZONE_MSB:`OD_DEADZONE_LSB];
  assign div_code = orientation_result_config_reg[`OD_DIVISOR_MSB:`OD_DIVISOR_LSB];

  // A changed rate or divisor restarts averaging; a stale window would mix depths
  // Combinational, so the clear lands on the same edge as the write
  always_comb begin
    restart = 1'b0;
    // Rewriting the same rate leaves a running window alone
    if (reg_wr && reg_addr == `OD_RATE_CONFIG_OFS && reg_wdata != rate_config_reg) begin
      restart = 1'b1;
    end
    // New depth only; a deadzone-only write keeps the window
    if (reg_wr && reg_addr == `OD_ORIENTATION_RESULT_CONFIG_OFS &&
        reg_wdata[`OD_DIVISOR_MSB:`OD_DIVISOR_LSB] != div_code) begin
      restart = 1'b1;
    end
  end

  // Writable configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      rate_config_reg   <= `OD_RATE_CONFIG_RST;
      orientation_result_config_reg <= `OD_ORIENTATION_RESULT_CONFIG_RST;
    end else if (reg_wr) begin
      // Writes to the result or to unmapped addresses fall through
      if (reg_addr == `OD_RATE_CONFIG_OFS) begin
        rate_config_reg <= reg_wdata;
      end
      if (reg_addr == `OD_ORIENTATION_RESULT_CONFIG_OFS) begin
        orientation_result_config_reg <= reg_wdata;
      end
    end
  end

  // One independent averager per axis
  od_mavg #(.W(16), .MAX_LOG(8)) u_mavg_x (
    .clk        (clk),
    .rst        (rst),
    .clear      (restart),
    .depth_code (div_code),
    .in_valid   (sample_valid),
    .in_data    (accel_x),
    .out_valid  (fv[0]),
    .out_data   (fx)
  );

  // y averager, same depth and clear as x
  od_mavg #(.W(16), .MAX_LOG(8)) u_mavg_y (
    .clk        (clk),
    .rst        (rst),
    .clear      (restart),
    .depth_code (div_code),
    .in_valid   (sample_valid),
    .in_data    (accel_y),
    .out_valid  (fv[1]),
    .out_data   (fy)
  );

  // z averager; all three publish on the same cycle
  od_mavg #(.W(16), .MAX_LOG(8)) u_mavg_z (
    .clk        (clk),
    .rst        (rst),
    .clear      (restart),
    .depth_code (div_code),
    .in_valid   (sample_valid),
    .in_data    (accel_z),
    .out_valid  (fv[2]),
    .out_data   (fz)
  );

  // Magnitudes feed both classifiers
  assign ax = od_abs(fx);
  assign ay = od_abs(fy);
  assign az = od_abs(fz);

  // Planar: only x and y; dominant axis and its sign give the code
  // z plays no part, so near flat the planar answer rests on small x and y
  always_comb begin
    // x wins ties, so an exact diagonal reads as portrait
    if (ax >= ay) begin
      planar_code  = fx[15] ? `OD_P2_NEG_X : `OD_P2_POS_X;
      planar_valid = od_in_region(ay, ax, dz_code);
    end else begin
      // y strictly dominant
      planar_code  = fy[15] ? `OD_P2_NEG_Y : `OD_P2_POS_Y;
      planar_valid = od_in_region(ax, ay, dz_code);
    end
  end

  // Spatial: face pointing up; both other axes must clear the deadzone
  // Same tie order as the planar path, so both agree whenever both are valid and the face is an x or y face
  always_comb begin
    // x wins ties over y and z: front or back face up
    if (ax >= ay && ax >= az) begin
      spatial_code  = fx[15] ? `OD_S3_NEG_X : `OD_S3_POS_X;
      spatial_valid = od_in_region(ay, ax, dz_code) && od_in_region(az, ax, dz_code);
    end else if (ay >= az) begin
      // y wins ties over z: right or left face up
      spatial_code  = fy[15] ? `OD_S3_NEG_Y : `OD_S3_POS_Y;
      spatial_valid = od_in_region(ax, ay, dz_code) && od_in_region(az, ay, dz_code);
    end else begin
      // z strictly dominant: top or bottom face up
      spatial_code  = fz[15] ? `OD_S3_NEG_Z : `OD_S3_POS_Z;
      spatial_valid = od_in_region(ax, az, dz_code) && od_in_region(ay, az, dz_code);
    end
  end

  // Result refreshed on each filtered sample; restart empties it
  always_ff @(posedge clk) begin
    // Restart wins over a filtered sample in the same cycle
    if (rst || restart) begin
      orientation_result_result_reg <= `OD_ORIENTATION_RESULT_RESULT_RST;
    end else if (fv[0]) begin
      // Bit 7 has no meaning and always reads zero
      orientation_result_result_reg <= {1'b0, planar_valid, planar_code,
                            spatial_valid, spatial_code};
    end
  end

  // Registered read port; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata_reg <= 8'h00;
    end else begin
      // Result is read-only; only the classifiers, a restart and reset ever change it
      unique case (reg_addr)
        `OD_RATE_CONFIG_OFS:   reg_rdata_reg <= rate_config_reg;
        `OD_ORIENTATION_RESULT_CONFIG_OFS: reg_rdata_reg <= orientation_result_config_reg;
        `OD_ORIENTATION_RESULT_RESULT_OFS: reg_rdata_reg <= orientation_result_result_reg;
        default:               reg_rdata_reg <= 8'h00;
      endcase
    end
  end

  // Data output straight from the flop, no decode after it
  assign reg_rdata = reg_rdata_reg;

endmodule

//--- test/od_detector_chk.sv
// Port-level assertions for the orientation detector
`timescale 1ns/1ps
module od_detector_chk (
  input logic       clk,
  input logic       rst,
  input logic       sample_valid,
  input logic [7:0] reg_addr,
  input logic       reg_wr,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata
);
  logic [7:0] rate_reg;  // Shadow of rate config
  logic [7:0] addr_reg;  // Address behind reg_rdata
  logic [1:0] sv_reg;    // Recent sample strobes
  logic       rd_res;    // Result register on reg_rdata
  logic [1:0] pl_exp;    // Planar code implied by face

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Rate shadow, so a real change can be told apart
  always_ff @(posedge clk) begin
    if (rst) rate_reg <= 8'h00;
    else if (reg_wr && reg_addr == 8'h3A) rate_reg <= reg_wdata;
  end
  // Read data lags the address by one cycle
  always_ff @(posedge clk) addr_reg <= reg_addr;
  always_ff @(posedge clk) sv_reg <= {sv_reg[0], sample_valid};
  assign rd_res = (addr_reg == 8'h3C);
  assign pl_exp = (reg_rdata[2:0] == 3'h3) ? 2'h0 : (reg_rdata[2:0] == 3'h4) ? 2'h1 :
                  (reg_rdata[2:0] == 3'h2) ? 2'h2 : 2'h3;

  // Rate change with no sample in flight
  sequence s_rate_chg;
    reg_wr && reg_addr == 8'h3A && reg_wdata != rate_reg && !sample_valid && sv_reg == 2'b00;
  endsequence
  sequence s_res_look;
    !sample_valid ##1 (!sample_valid && reg_addr == 8'h3C)[*2];
  endsequence

  property p_bit7;
    rd_res |-> !reg_rdata[7];
  endproperty
  property p_unmap;
    !(addr_reg inside {8'h3A, 8'h3B, 8'h3C}) |-> reg_rdata == 8'h00;
  endproperty
  property p_cfg;
    reg_wr && reg_addr == 8'h3B ##1 reg_addr == 8'h3B |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  property p_rate;
    reg_wr && reg_addr == 8'h3A ##1 reg_addr == 8'h3A |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  // Without a sample the result may not move
  property p_hold;
    (!sample_valid && reg_addr == 8'h3C)[*4] |=> $stable(reg_rdata);
  endproperty
  property p_code;
    rd_res && reg_rdata[3] |-> reg_rdata[2:0] inside {[3'h1:3'h6]};
  endproperty
  property p_cons;
    rd_res && reg_rdata[3] && reg_rdata[2:0] inside {[3'h2:3'h5]} |-> reg_rdata[6] && reg_rdata[5:4] == pl_exp;
  endproperty
  property p_restart;
    s_rate_chg ##1 s_res_look |=> reg_rdata == 8'h00;
  endproperty

  a_bit7: assert property (p_bit7) else $error("result bit 7 set");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_cfg: assert property (p_cfg) else $error("orientation config readback wrong");
  a_rate: assert property (p_rate) else $error("rate config readback wrong");
  a_hold: assert property (p_hold) else $error("result moved without sample");
  a_code: assert property (p_code) else $error("spatial code out of range");
  a_cons: assert property (p_cons) else $error("planar code disagrees with face");
  a_restart: assert property (p_restart) else $error("rate change did not clear result");
endmodule

bind od_detector od_detector_chk u_od_detector_chk (.clk(clk), .rst(rst), .sample_valid(sample_valid),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

//--- test/od_host.sv
// Host model driving the register port
`timescale 1ns/1ps
module od_host (
  input  logic       clk,
  output logic [7:0] reg_addr,
  output logic       reg_wr,
  output logic [7:0] reg_wdata,
  input  logic [7:0] reg_rdata
);
  // Idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // One strobe; data inverted after, never left stale
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // Extra cycle so a fresh result has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    #1 d = reg_rdata;
  endtask
endmodule

//--- test/od_detector_tb_top.sv
// Self-checking bench for the orientation detector
`timescale 1ns/1ps
module od_detector_tb_top;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               sample_valid = 1'b0;
  od_pkg::od_sample_t accel_x = 16'h0000;
  od_pkg::od_sample_t accel_y = 16'h0000;
  od_pkg::od_sample_t accel_z = 16'h0000;
  od_pkg::od_sample_t v;       // Signed gravity for a face
  logic [7:0]         reg_addr;
  logic [7:0]         reg_wdata;
  logic [7:0]         reg_rdata;
  logic [7:0]         rv;      // Last read value
  logic               reg_wr;
  logic [7:0]         fexp[6] = '{8'h4B, 8'h5C, 8'h6A, 8'h7D, 8'h09, 8'h0E};
  int                 n_mismatch = 0;
  int                 cmp_count = 0;

  always #2 clk = ~clk;

  od_detector u_od_detector (.clk(clk), .rst(rst), .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z),
    .sample_valid(sample_valid), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  od_host u_od_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
    u_od_host.rd(a, rv);
    chk(nm, e, rv);
  endtask
  // Samples spaced two cycles apart
  task automatic smp(input od_pkg::od_sample_t x, input od_pkg::od_sample_t y, input od_pkg::od_sample_t z,
                     input int n);
    repeat (n) begin
      @(posedge clk);
      accel_x <= x;
      accel_y <= y;
      accel_z <= z;
      sample_valid <= 1'b1;
      @(posedge clk);
      sample_valid <= 1'b0;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc(8'h3B, 8'h00, "conf_rst");
    rdc(8'h3C, 8'h00, "res_rst");
    rdc(8'h10, 8'h00, "unmapped");
    // Depth 2: two samples refill the window
    for (int i = 0; i < 6; i++) begin
      v = (i % 2) ? 16'hFC18 : 16'h03E8;
      smp((i < 2) ? v : 16'h0000, (i / 2 == 1) ? v : 16'h0000, (i > 3) ? v : 16'h0000, 2);
      rdc(8'h3C, fexp[i], "face");
    end
    u_od_host.wr(8'h3B, 8'h70);
    rdc(8'h3B, 8'h70, "conf");
    rdc(8'h3C, 8'h0E, "dz_keep");
    // Widest deadzone, one count either side of its edge
    smp(16'h03E8, 16'h0279, 16'h0000, 2);
    rdc(8'h3C, 8'h03, "dz_in");
    smp(16'h03E8, 16'h0278, 16'h0000, 2);
    rdc(8'h3C, 8'h4B, "dz_out");
    u_od_host.wr(8'h3C, 8'hFF);
    rdc(8'h3C, 8'h4B, "read_only");
    // Depth 4 restarts; after three z samples, the second x sample turns the face
    u_od_host.wr(8'h3B, 8'h01);
    rdc(8'h3C, 8'h00, "restart");
    smp(16'h0000, 16'h0000, 16'h03E8, 3);
    smp(16'h07D0, 16'h0000, 16'h0000, 1);
    rdc(8'h3C, 8'h49, "avg4_a");
    smp(16'h07D0, 16'h0000, 16'h0000, 1);
    rdc(8'h3C, 8'h4B, "avg4_b");
    u_od_host.wr(8'h3A, 8'h0A);
    rdc(8'h3C, 8'h00, "rate_restart");
    u_od_host.wr(8'h3A, 8'h0A);
    rdc(8'h3A, 8'h0A, "rate");
    stop_test();
  end
endmodule
